/* File: tfp_timer16.v */
// 16-bit up-counter with two capture/compare registers, PPG and one-shot.
// Assumes inputs synchronous to ref_clk and a strobe register port.
//
// What this block does
// - Mode 01 counts up every count clock, never cleared by compare.
// - After FFFF the next count clock sets overflow, wraps to 0000.
// - Overflow flag stays set until software writes zero to it.
// - Each capture/compare register is compare or capture independently.
// - With output enabled, pin toggles on a compare match whose toggle bit is set; coincident matches cancel.
// - First register match raises irq A, second raises irq B.
// - Second register in capture copies count on trigger A edge, irq B.
// - First capture, role bit 1 clear: trigger B edge copies count into first register.
// - Trigger B edges never capture into the second register.
// - Mode 11 clears the counter on first register match, PPG wave.
// - PPG period is first register plus one count clocks.
// - PPG active part is second register plus one count clocks.
// - One-shot only in mode 01 or 10 with one-shot enable set.
// - One-shot trigger restarts counter, one pulse of register difference.
// - One-shot first register match raises irq A and toggles output.
// - One-shot second register match raises irq B and toggles output.
// - Counter reads return the live count without disturbing it.
// - Edge field: 00 falling, 01 rising, 11 both, 10 none.
// - Mode 10 clears and restarts on trigger A edge; 00 stops.
// - Role bit 0 means compare, 1 means capture, per register.
`timescale 1ns/1ps
`default_nettype none
`include "tfp_consts.vh"

module tfp_timer16 (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        resetn,
	// Register port
	input  wire [2:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	// Trigger pins
	input  wire        trigger_input_a,
	input  wire        trigger_input_b,
	// Timer output pin and interrupt pulses
	output reg         timer_output_pin,
	output reg         timer_output_oe,
	output reg         irq_a,
	output reg         irq_b
);

	// Software-visible state
	reg [1:0]  mode_r;
	reg        overflow_flag_r;
	reg [2:0]  role_r;
	reg [5:0]  outctl_r;
	reg [5:0]  edge_r;
	reg [15:0] up_counter_r;
	reg [15:0] capcomp_first_r;
	reg [15:0] capcomp_second_r;

	// Prescaler, trigger synchronisers, one-shot state
	reg [2:0]  ps_r;
	reg        ta_meta_r;
	reg        ta_sync_r;
	reg        ta_prev_r;
	reg        tb_meta_r;
	reg        tb_sync_r;
	reg        tb_prev_r;
	reg [3:0]  os_state_r;
	reg [3:0]  os_state_nxt;

	// One-shot sequencer states, one-hot
	localparam [3:0] OS_IDLE = 4'b0001;
	localparam [3:0] OS_ARM  = 4'b0010;
	localparam [3:0] OS_RUN1 = 4'b0100;
	localparam [3:0] OS_RUN2 = 4'b1000;

	// Valid edge test on one count clock
	function edge_hit;
		input [1:0] sel;
		input       prev;
		input       cur;
		begin
			case (sel)
				`TFP_EDGE_FALL: edge_hit = prev & ~cur;
				`TFP_EDGE_RISE: edge_hit = ~prev & cur;
				`TFP_EDGE_BOTH: edge_hit = prev ^ cur;
				default:        edge_hit = 1'b0;
			endcase
		end
	endfunction

	// Read data for one register index; no side effects
	function [15:0] rd_mux;
		input [2:0] idx;
		begin
			case (idx)
				`TFP_ADR_MODE:
					rd_mux = {12'h000, mode_r, 1'b0, overflow_flag_r};
				`TFP_ADR_ROLE:   rd_mux = {13'h0000, role_r};
				`TFP_ADR_OUTCTL:
					rd_mux = {10'h000, outctl_r[5:4], 2'b00,
					          outctl_r[1:0]};
				`TFP_ADR_EDGE:   rd_mux = {10'h000, edge_r};
				`TFP_ADR_COUNT:  rd_mux = up_counter_r;
				`TFP_ADR_CC1:    rd_mux = capcomp_first_r;
				`TFP_ADR_CC2:    rd_mux = capcomp_second_r;
				default:         rd_mux = 16'h0000;
			endcase
		end
	endfunction

	// Decoded fields
	wire [1:0] es_a      = edge_r[`TFP_ES_A_HI:`TFP_ES_A_LO];
	wire [1:0] es_b      = edge_r[`TFP_ES_B_HI:`TFP_ES_B_LO];
	wire [1:0] ps_sel    = edge_r[`TFP_PS_HI:`TFP_PS_LO];
	wire       first_cap = role_r[`TFP_ROLE_FIRST];
	wire       second_cap = role_r[`TFP_ROLE_SECOND];
	wire       out_en    = outctl_r[`TFP_OC_OUTEN];
	wire       wr_mode   = reg_wr && (reg_addr == `TFP_ADR_MODE);
	wire       wr_outctl = reg_wr && (reg_addr == `TFP_ADR_OUTCTL);

	// Count clock enable: ref_clk divided by 1, 2, 4 or 8
	wire [2:0] ps_mask = (ps_sel == 2'b00) ? 3'b000 :
	                     (ps_sel == 2'b01) ? 3'b001 :
	                     (ps_sel == 2'b10) ? 3'b011 : 3'b111;
	wire       tick    = ((ps_r & ps_mask) == ps_mask);
	wire       running = (mode_r != `TFP_MODE_STOP);

	// edge decode, once per count clock
	wire edge_a     = tick && edge_hit(es_a, ta_prev_r, ta_sync_r);
	wire edge_b     = tick && edge_hit(es_b, tb_prev_r, tb_sync_r);
	// Reverse phase of trigger A for the first register
	wire rev_sel_fall = (es_a == `TFP_EDGE_RISE);
	wire edge_a_rev = tick && (rev_sel_fall ? (ta_prev_r & ~ta_sync_r) :
	                                          (~ta_prev_r & ta_sync_r));

	// role bits pick compare or capture
	wire match1 = tick && running && !first_cap &&
	              (up_counter_r == capcomp_first_r);
	wire match2 = tick && running && !second_cap &&
	              (up_counter_r == capcomp_second_r);

	wire os_mode = outctl_r[`TFP_OC_OSPE] &&
	               ((mode_r == `TFP_MODE_FREE) ||
	                (mode_r == `TFP_MODE_EDGECLR));
	// Armed: the next count clock restarts the counter
	wire os_pend = (os_state_r == OS_ARM);
	// Running: toggles still allowed for this pulse
	wire os_run  = (os_state_r == OS_RUN1) || (os_state_r == OS_RUN2);

	// Captures
	// trigger A into second register
	wire cap2 = running && second_cap && edge_a;
	// trigger B into first, or reverse phase of A
	wire cap1 = running && first_cap &&
	            (role_r[`TFP_ROLE_TRIGSEL] ? edge_a_rev : edge_b);

	// Counter next value
	reg [15:0] cnt_nxt;
	reg        ovf_set;
	always @* begin
		cnt_nxt = up_counter_r;
		ovf_set = 1'b0;
		if (!running) begin
			// stop holds the count at zero
			cnt_nxt = `TFP_CNT_ZERO;
		end else if (tick) begin
			if (os_pend) begin
				cnt_nxt = `TFP_CNT_ZERO;
			end else if (mode_r == `TFP_MODE_EDGECLR && edge_a) begin
				// clear and start on trigger A
				cnt_nxt = `TFP_CNT_ZERO;
			end else if (mode_r == `TFP_MODE_PPG &&
			             up_counter_r == capcomp_first_r) begin
				cnt_nxt = `TFP_CNT_ZERO;
			end else if (up_counter_r == `TFP_CNT_MAX) begin
				cnt_nxt = `TFP_CNT_ZERO;
				ovf_set = 1'b1;
			end else begin
				cnt_nxt = up_counter_r + 16'h0001;
			end
		end
	end

	// Output toggle decision
	wire tgl1 = match1 && outctl_r[`TFP_OC_TGL1];
	wire tgl2 = match2 && outctl_r[`TFP_OC_TGL2];
	// one-shot gates toggles to its single pulse
	wire os_gate = !os_mode || os_run;
	// Coincident matches cancel, as two inversions restore the level
	wire do_tgl  = out_en && os_gate && (tgl1 ^ tgl2);

	// trigger only counts while running outside PPG
	wire os_trig_wr = wr_outctl && reg_wdata[`TFP_OC_OSPT] &&
	                  reg_wdata[`TFP_OC_OSPE] && running &&
	                  (mode_r != `TFP_MODE_PPG);

	// one-shot sequence: arm, restart, then two gated matches
	always @* begin
		os_state_nxt = os_state_r;
		if (os_trig_wr) begin
			os_state_nxt = OS_ARM;
		end else begin
			case (os_state_r)
				OS_IDLE: begin
					os_state_nxt = OS_IDLE;
				end
				OS_ARM: begin
					if (tick)
						os_state_nxt = os_mode ? OS_RUN1 : OS_IDLE;
				end
				OS_RUN1: begin
					if (!os_mode)
						os_state_nxt = OS_IDLE;
					else if (match1 || match2)
						os_state_nxt = OS_RUN2;
				end
				OS_RUN2: begin
					// Second edge ends the pulse; later matches still raise irqs but no longer toggle the pin
					if (!os_mode || match1 || match2)
						os_state_nxt = OS_IDLE;
				end
				default: begin
					os_state_nxt = OS_IDLE;
				end
			endcase
		end
	end

	always @(posedge ref_clk) begin
		if (!resetn) begin
			ps_r      <= 3'b000;
			ta_meta_r <= 1'b0;
			ta_sync_r <= 1'b0;
			ta_prev_r <= 1'b0;
			tb_meta_r <= 1'b0;
			tb_sync_r <= 1'b0;
			tb_prev_r <= 1'b0;
		end else begin
			ps_r      <= ps_r + 3'b001;
			ta_meta_r <= trigger_input_a;
			ta_sync_r <= ta_meta_r;
			tb_meta_r <= trigger_input_b;
			tb_sync_r <= tb_meta_r;
			// Edge history advances only on count clocks
			if (tick) begin
				ta_prev_r <= ta_sync_r;
				tb_prev_r <= tb_sync_r;
			end
		end
	end

	always @(posedge ref_clk) begin
		if (!resetn) begin
			mode_r           <= `TFP_MODE_STOP;
			overflow_flag_r  <= 1'b0;
			role_r           <= 3'b000;
			outctl_r         <= 6'b00_0000;
			edge_r           <= 6'b00_0000;
			up_counter_r     <= `TFP_CNT_ZERO;
			capcomp_first_r  <= `TFP_CNT_ZERO;
			capcomp_second_r <= `TFP_CNT_ZERO;
			os_state_r       <= OS_IDLE;
			timer_output_pin <= 1'b0;
			timer_output_oe  <= 1'b0;
			irq_a            <= 1'b0;
			irq_b            <= 1'b0;
			reg_rdata        <= 16'h0000;
		end else begin
			up_counter_r    <= cnt_nxt;
			timer_output_oe <= out_en;

			// cleared only by software, set wins
			// A wrap in the clearing cycle wins so no overflow goes unseen
			if (ovf_set)
				overflow_flag_r <= 1'b1;
			else if (wr_mode && !reg_wdata[`TFP_MODE_OVF])
				overflow_flag_r <= 1'b0;

			if (cap1)
				capcomp_first_r <= up_counter_r;
			else if (reg_wr && reg_addr == `TFP_ADR_CC1)
				capcomp_first_r <= reg_wdata;
			if (cap2)
				capcomp_second_r <= up_counter_r;
			else if (reg_wr && reg_addr == `TFP_ADR_CC2)
				capcomp_second_r <= reg_wdata;

			// compare irqs; capture on B-edge also flags irq A
			irq_a <= match1 ||
			         (running && first_cap && edge_b);
			irq_b <= match2 || cap2;

			if (do_tgl) begin
				timer_output_pin <= ~timer_output_pin;
			end else if (wr_outctl && !running) begin
				// Software level set/clear while stopped
				if (reg_wdata[`TFP_OC_LVS] && !reg_wdata[`TFP_OC_LVR])
					timer_output_pin <= 1'b1;
				else if (reg_wdata[`TFP_OC_LVR] &&
				         !reg_wdata[`TFP_OC_LVS])
					timer_output_pin <= 1'b0;
			end

			os_state_r <= os_state_nxt;

			// Register writes
			if (wr_mode)
				mode_r <= reg_wdata[`TFP_MODE_HI:`TFP_MODE_LO];
			if (reg_wr && reg_addr == `TFP_ADR_ROLE)
				role_r <= reg_wdata[2:0];
			if (wr_outctl)
				outctl_r <= {reg_wdata[`TFP_OC_OSPE],
				             reg_wdata[`TFP_OC_TGL2],
				             2'b00,
				             reg_wdata[`TFP_OC_TGL1],
				             reg_wdata[`TFP_OC_OUTEN]};
			if (reg_wr && reg_addr == `TFP_ADR_EDGE)
				edge_r <= reg_wdata[5:0];

			// reads have no side effects
			// Idle cycles read zero so stale data never lingers
			if (reg_rd)
				reg_rdata <= rd_mux(reg_addr);
			else
				reg_rdata <= 16'h0000;
		end
	end

endmodule

`default_nettype wire

/* File: tfp_consts.vh */
// Constants for the 16-bit free-running / PPG / one-shot timer.
// Assumes word-indexed registers on a plain strobe port.
`ifndef TFP_CONSTS_VH
`define TFP_CONSTS_VH

// Register indices on the 3-bit address port
`define TFP_ADR_MODE      3'h0
`define TFP_ADR_ROLE      3'h1
`define TFP_ADR_OUTCTL    3'h2
`define TFP_ADR_EDGE      3'h3
`define TFP_ADR_COUNT     3'h4
`define TFP_ADR_CC1       3'h5
`define TFP_ADR_CC2       3'h6

// mode_control_reg fields
`define TFP_MODE_OVF      0
`define TFP_MODE_LO       2
`define TFP_MODE_HI       3
`define TFP_MODE_STOP     2'b00
`define TFP_MODE_FREE     2'b01
`define TFP_MODE_EDGECLR  2'b10
`define TFP_MODE_PPG      2'b11

// role_select_reg fields
`define TFP_ROLE_FIRST    0
`define TFP_ROLE_TRIGSEL  1
`define TFP_ROLE_SECOND   2

// output_control_reg fields
`define TFP_OC_OUTEN      0
`define TFP_OC_TGL1       1
`define TFP_OC_LVR        2
`define TFP_OC_LVS        3
`define TFP_OC_TGL2       4
`define TFP_OC_OSPE       5
`define TFP_OC_OSPT       6

// edge/prescaler register fields
`define TFP_ES_A_LO       0
`define TFP_ES_A_HI       1
`define TFP_ES_B_LO       2
`define TFP_ES_B_HI       3
`define TFP_PS_LO         4
`define TFP_PS_HI         5

// Edge encodings
`define TFP_EDGE_FALL     2'b00
`define TFP_EDGE_RISE     2'b01
`define TFP_EDGE_NONE     2'b10
`define TFP_EDGE_BOTH     2'b11

// Counter values
`define TFP_CNT_ZERO      16'h0000
`define TFP_CNT_MAX       16'hFFFF

`endif

/* File: tfp_timer16_props.sv */
// Port checker for tfp_timer16, with its bind statement.
// Assumes the strobe register map and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module tfp_timer16_props (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        resetn,
	// Register port
	input wire logic [2:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// Pins and interrupts
	input wire logic        trigger_input_a,
	input wire logic        trigger_input_b,
	input wire logic        timer_output_pin,
	input wire logic        timer_output_oe,
	input wire logic        irq_a,
	input wire logic        irq_b
);
	logic [1:0] mode_r;
	logic [2:0] role_r;
	logic [3:0] qa_r, qb_r, sa_r;
	logic       ta_r, tb_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Mirror of mode and role, plus saturating quiet-time counters
	always @(posedge ref_clk) begin
		ta_r <= trigger_input_a;
		tb_r <= trigger_input_b;
		if (!resetn) begin
			mode_r <= 2'b00;
			role_r <= 3'b000;
			qa_r   <= 4'h0;
			qb_r   <= 4'h0;
			sa_r   <= 4'h0;
		end else begin
			if (reg_wr && reg_addr == 3'h0)
				mode_r <= reg_wdata[3:2];
			if (reg_wr && reg_addr == 3'h1)
				role_r <= reg_wdata[2:0];
			qa_r <= (reg_wr || ta_r != trigger_input_a) ? 4'h0 : qa_r + {3'h0, ~&qa_r};
			qb_r <= (reg_wr || tb_r != trigger_input_b) ? 4'h0 : qb_r + {3'h0, ~&qb_r};
			sa_r <= (mode_r != 2'b00) ? 4'h0 : sa_r + {3'h0, ~&sa_r};
		end
	end
	a_rdata_idle:
	assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside read slot");
	a_unmapped_zero:
	assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_reset_quiet:
	assert property ($rose(resetn) |-> !timer_output_pin && !timer_output_oe
		&& !irq_a && !irq_b)
		else $error("outputs active after reset");
	a_oe_follows:
	assert property (reg_wr && reg_addr == 3'h2 |=> ##1
		timer_output_oe == $past(reg_wdata[0], 2))
		else $error("output enable mismatch");
	a_toggle_irq:
	assert property ($changed(timer_output_pin) && mode_r != 2'b00 &&
		$past(mode_r) != 2'b00 |-> ##[0:2] (irq_a || irq_b))
		else $error("output toggled without interrupt");
	a_capb_quiet:
	assert property (qa_r == 4'hf && role_r[2] |-> !irq_b)
		else $error("second capture irq without edge");
	a_capa_quiet:
	assert property (qb_r == 4'hf && role_r[0] |-> !irq_a)
		else $error("first capture irq without edge");
	a_stop_zero:
	assert property (reg_rd && reg_addr == 3'h4 && sa_r == 4'hf |=>
		reg_rdata == 16'h0000)
		else $error("stopped counter not zero");
endmodule
bind tfp_timer16 tfp_timer16_props u_props (.ref_clk(ref_clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_input_a(trigger_input_a),
	.trigger_input_b(trigger_input_b), .timer_output_pin(timer_output_pin),
	.timer_output_oe(timer_output_oe), .irq_a(irq_a), .irq_b(irq_b));
`default_nettype wire

/* File: tfp_pulse_src.sv */
// Pulse source model driving both trigger pins.
// Assumes one level change per one-cycle flip request.
`timescale 1ns/1ps
`default_nettype none
module tfp_pulse_src (
	// Clock
	input wire logic  ref_clk,
	// Flip requests
	input wire logic  flip_a,
	input wire logic  flip_b,
	// Trigger pins
	output var logic  trig_a,
	output var logic  trig_b
);
	initial begin
		trig_a = 1'b0;
		trig_b = 1'b0;
	end
	always @(posedge ref_clk) begin
		if (flip_a)
			trig_a <= ~trig_a;
		if (flip_b)
			trig_b <= ~trig_b;
	end
endmodule
`default_nettype wire

/* File: tb_tfp_timer16.sv */
// Self-checking bench: registers, capture, overflow, PPG, one-shot.
// Assumes the pulse source model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_tfp_timer16;
	logic        ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
	logic        flip_a = 0, flip_b = 0, trig_a, trig_b, pin, oe, irq_a, irq_b;
	logic        pin_d = 0;
	logic [2:0]  reg_addr = 0;
	logic [15:0] reg_wdata = 0, reg_rdata;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h3313_98d5;
	logic [31:0] ia = 0, ib = 0, tg = 0, t0, a0, b0, h, l;
	logic [1:0]  ecode[3] = '{2'b00, 2'b01, 2'b11};
	int          failures = 0, tests_run = 0, k;
	always #5 ref_clk = ~ref_clk;
	tfp_timer16 DUT (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .trigger_input_a(trig_a), .trigger_input_b(trig_b),
		.timer_output_pin(pin), .timer_output_oe(oe), .irq_a(irq_a), .irq_b(irq_b));
	tfp_pulse_src u_src (.ref_clk(ref_clk), .flip_a(flip_a), .flip_b(flip_b),
		.trig_a(trig_a), .trig_b(trig_b));
	always @(posedge ref_clk) begin
		rd_d  <= reg_rd;
		ia    <= ia + {31'h0, irq_a === 1'b1};
		ib    <= ib + {31'h0, irq_b === 1'b1};
		pin_d <= pin;
		tg    <= tg + {31'h0, pin !== pin_d};
	end
	always @(negedge ref_clk) if (rd_d) chk("rdata", reg_rdata, exp_q.pop_front());
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1;
		@(posedge ref_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1;
		exp_q.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 0;
	endtask
	task fl(input logic a, input logic b);
		@(posedge ref_clk);
		flip_a <= a;
		flip_b <= b;
		@(posedge ref_clk);
		flip_a <= 0;
		flip_b <= 0;
		repeat (8) @(posedge ref_clk);
	endtask
	// Cycles until the next output change, bounded
	task gap(output logic [31:0] d);
		logic [31:0] t;
		t = tg;
		d = 0;
		while (tg == t && d < 400) begin
			@(posedge ref_clk);
			d++;
		end
	endtask
	task end_sim;
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#900000;
		failures++;
		end_sim;
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1;
		for (k = 0; k < 8; k++) rd(k[2:0], 16'h0000);
		wr(3'h1, 16'h0005);
		rd(3'h1, 16'h0005);
		wr(3'h2, 16'h0000);
		wr(3'h0, 16'h0004);
		for (k = 0; k < 3; k++) begin
			wr(3'h3, {12'h000, 2'b11, ecode[k]});
			a0 = ia;
			b0 = ib;
			fl(1, 0);
			fl(1, 0);
			chk("irq_b_cap", ib - b0, (k == 2) ? 2 : 1);
			seed = lfsr(seed);
			repeat (seed[1:0] + 1) fl(0, 1);
			chk("irq_a_cap", ia - a0, seed[1:0] + 1);
			chk("irq_b_only", ib - b0, (k == 2) ? 2 : 1);
		end
		wr(3'h0, 16'h0000);
		wr(3'h1, 16'h0000);
		wr(3'h5, 16'h0010);
		wr(3'h6, 16'h0100);
		wr(3'h2, 16'h0013);
		rd(3'h2, 16'h0013);
		t0 = tg;
		a0 = ia;
		b0 = ib;
		wr(3'h0, 16'h0004);
		repeat (65664) @(posedge ref_clk);
		chk("toggles", tg - t0, 3);
		chk("irq_a_cmp", ia - a0, 2);
		chk("irq_b_cmp", ib - b0, 1);
		chk("oe", {31'h0, oe}, 1);
		rd(3'h0, 16'h0005);
		wr(3'h0, 16'h0005);
		rd(3'h0, 16'h0005);
		wr(3'h0, 16'h0004);
		rd(3'h0, 16'h0004);
		wr(3'h0, 16'h0000);
		wr(3'h5, 16'h0007);
		wr(3'h6, 16'h0002);
		wr(3'h0, 16'h000c);
		gap(h);
		gap(h);
		gap(l);
		chk("ppg_period", h + l, 8);
		chk("ppg_duty", h * l, 15);
		wr(3'h0, 16'h0000);
		wr(3'h5, 16'h0030);
		wr(3'h6, 16'h0010);
		t0 = tg;
		wr(3'h2, 16'h0073);
		rd(3'h2, 16'h0033);
		repeat (100) @(posedge ref_clk);
		chk("stop_quiet", tg - t0, 0);
		rd(3'h4, 16'h0000);
		a0 = ia;
		b0 = ib;
		wr(3'h0, 16'h0004);
		wr(3'h2, 16'h0073);
		gap(h);
		gap(h);
		repeat (300) @(posedge ref_clk);
		chk("shot_width", h, 32);
		chk("shot_count", tg - t0, 2);
		chk("irq_a_shot", ia - a0, 1);
		chk("irq_b_shot", ib - b0, 1);
		end_sim;
	end
endmodule
`default_nettype wire
